// ==== rtl/tssr_defs.vh ====
// Purpose: constants for the transceiver status readout block
// Assumes: core clock at 250 MHz
// Notes:   bit positions, fixed reserved pattern and timing counts
`ifndef TSSR_DEFS_VH
`define TSSR_DEFS_VH

`define TSSR_WORD_W          16
`define TSSR_BIT_WAKE        0
`define TSSR_BIT_ACTIVE      1
`define TSSR_BIT_TX_ON       2
`define TSSR_BIT_GUARD       3
`define TSSR_BIT_POWER_ON_FLAG        4
`define TSSR_BIT_BUS_ERR     5
`define TSSR_BIT_TEMP        6
`define TSSR_BIT_TRANSMIT_ENABLE_LOW_STUCK  7
`define TSSR_BIT_UV_CORE     8
`define TSSR_BIT_UV_IO       9
`define TSSR_BIT_SER_FAULT   10
`define TSSR_BIT_PARITY      15
`define TSSR_RSVD_PATTERN    4'h_a
`define TSSR_CLK_PERIOD_NS   4
`define TSSR_DETECT_TIME_NS  1000
`define TSSR_ERR_HOLD_NS     1000
`define TSSR_DETECT_CYC      (`TSSR_DETECT_TIME_NS / `TSSR_CLK_PERIOD_NS)
`define TSSR_ERR_HOLD_CYC    (`TSSR_ERR_HOLD_NS / `TSSR_CLK_PERIOD_NS)
`define TSSR_BIT_CNT_W       5

`endif

// ==== rtl/tssr_sync.v ====
// Purpose: two flip-flop synchroniser for asynchronous pin levels
// Assumes: one clock domain, synchronous active-low reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module tssr_sync #(
    parameter       WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input  wire             core_clk_in,  // core clock
    input  wire             rst_n_in,     // synchronous reset, low
    input  wire [WIDTH-1:0] async_in,     // asynchronous levels
    output reg  [WIDTH-1:0] sync_out      // synchronised levels
);
    reg [WIDTH-1:0] stage1;

    always @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // tssr_sync

// ==== rtl/tssr_status_readout.v ====
// Purpose: status word, serial readout and error pin of a bus transceiver
// Assumes: serial pins arrive asynchronously and are synchronised here
// Notes:   serial clock sampled by core clock; edges found after sync
// Function
// - bits 0-3 mirror status flags, bit 4 holds the power-on flag, bits 5-10 hold error flags
// - bit 15 is even parity over the other fifteen bits
// - serial mode latches bits 4-10; clear after flag gone and good readout
// - latched bits 4-10 clear in power-off state
// - after power-up the block is in serial mode
// - select low, clock high beyond detect time enters simple mode
// - in simple mode, select rising edge returns to serial mode
// - io undervoltage blocks every mode change
// - serial mode error pin low while any bit 5-10 set
// - simple mode error pin low as soon as an error flag sets
// - simple mode error pin held low for a minimum time
// - simple mode: no latching and no readout
// - serial output tristate and clock ignored while select high
// - select low starts readout, output driven low until shifting
// - bits shift out on serial clock rising edges, set flag is high
// - exactly 16 clocks then select high is a good readout
// - more than 16 clocks sets serial fault, output tristate until select fall
// - fewer than 16 clocks sets serial fault when access ends
// - simple mode pulls select down, serial mode pulls select up
// - readout refused during io undervoltage
// - 16-bit word read only in serial mode
// - serial mode error pin driven only while standby control is high
`timescale 1ns/1ns
`include "tssr_defs.vh"
module tssr_status_readout #(
    parameter DETECT_CYC   = `TSSR_DETECT_CYC,   // mode switch detect
    parameter ERR_HOLD_CYC = `TSSR_ERR_HOLD_CYC  // error low min hold
) (
    input  wire        core_clk_in,             // 250 MHz core clock
    input  wire        rst_n_in,                // sync reset, low
    input  wire        power_off_in,            // device in power-off
    input  wire [10:0] flags_in,                // raw flags, bits 0-10
    input  wire        standby_control_low_in,  // standby pin level
    input  wire        select_line_low_in,      // serial select pin
    input  wire        serial_clk_in,           // serial clock pin
    output reg         serial_out_pin_out,      // serial data level
    output reg         serial_out_pin_oe_out,   // serial data enable
    output wire        error_out_low_out,       // error pin, low active
    output wire        select_pull_up_out,      // select pull-up on
    output wire        select_pull_down_out,    // select pull-down on
    output wire        simple_mode_out,         // simple mode active
    output wire [15:0] status_word_out          // current status word
);
    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    wire [2:0] pins_s;
    tssr_sync #(.WIDTH(3), .RESET_VAL(3'b0_11)) u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .async_in    ({standby_control_low_in, select_line_low_in,
                       serial_clk_in}),
        .sync_out    (pins_s)
    );
    wire stby_n = pins_s[2];
    wire sel_n  = pins_s[1];
    wire sclk   = pins_s[0];

    reg sel_d;
    reg sclk_d;
    wire sel_fall  = sel_d & ~sel_n;
    wire sel_rise  = ~sel_d & sel_n;
    wire sclk_rise = ~sclk_d & sclk;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function parity15;
        input [14:0] v;
        begin
            parity15 = ^v;
        end
    endfunction

    // ---------------------------------------------------------------
    // mode control
    // ---------------------------------------------------------------
    localparam [1:0] ST_SERIAL = 2'b01;
    localparam [1:0] ST_SIMPLE = 2'b10;
    reg [1:0]  mode;
    reg [31:0] det_cnt;
    wire uv_io  = flags_in[`TSSR_BIT_UV_IO];
    wire simple = mode[1];

    always @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            mode    <= ST_SERIAL;
            det_cnt <= 32'h_0000_0000;
        end
        else
        begin
            if (!sel_n && sclk && mode == ST_SERIAL)
                det_cnt <= det_cnt + 32'h_0000_0001;
            else
                det_cnt <= 32'h_0000_0000;
            case (mode)
                ST_SERIAL:
                begin
                    if (!uv_io && det_cnt >= DETECT_CYC)
                        mode <= ST_SIMPLE;
                end
                ST_SIMPLE:
                begin
                    if (!uv_io && sel_rise)
                        mode <= ST_SERIAL;
                end
                default:
                    mode <= ST_SERIAL;
            endcase
        end
    end
    assign simple_mode_out      = simple;
    assign select_pull_down_out = simple;
    assign select_pull_up_out   = ~simple;

    // ---------------------------------------------------------------
    // status word
    // ---------------------------------------------------------------
    reg  [6:0]  latched;
    reg         good_read;
    reg         ser_fault_set;
    wire [6:0]  raw_err = {ser_fault_set | flags_in[10], flags_in[9:4]};
    wire [14:0] low15   = {`TSSR_RSVD_PATTERN,
                           latched, flags_in[3:0]};
    assign status_word_out = {parity15(low15), low15};

    always @(posedge core_clk_in)
    begin
        if (!rst_n_in || power_off_in)
            latched <= 7'h_00;
        else if (simple)
            latched <= raw_err;
        else if (good_read)
            latched <= raw_err;
        else
            latched <= latched | raw_err;
    end

    // ---------------------------------------------------------------
    // serial readout
    // ---------------------------------------------------------------
    reg [15:0] shreg;
    reg [`TSSR_BIT_CNT_W-1:0] clk_cnt;
    reg active;
    reg overrun;

    always @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            sel_d                 <= 1'b1;
            sclk_d                <= 1'b1;
            shreg                 <= 16'h_0000;
            clk_cnt               <= 5'h_00;
            active                <= 1'b0;
            overrun               <= 1'b0;
            good_read             <= 1'b0;
            ser_fault_set         <= 1'b0;
            serial_out_pin_out    <= 1'b0;
            serial_out_pin_oe_out <= 1'b0;
        end
        else
        begin
            sel_d         <= sel_n;
            sclk_d        <= sclk;
            good_read     <= 1'b0;
            ser_fault_set <= 1'b0;
            if (sel_fall && !simple && !uv_io)
            begin
                active                <= 1'b1;
                overrun               <= 1'b0;
                clk_cnt               <= 5'h_00;
                shreg                 <= status_word_out;
                serial_out_pin_out    <= 1'b0;
                serial_out_pin_oe_out <= 1'b1;
            end
            else if (sel_n || simple || uv_io)
            begin
                if (active && sel_rise)
                begin
                    if (clk_cnt == 5'h_10 && !overrun)
                        good_read <= 1'b1;
                    else if (clk_cnt < 5'h_10)
                        ser_fault_set <= 1'b1;
                end
                active                <= 1'b0;
                serial_out_pin_oe_out <= 1'b0;
                serial_out_pin_out    <= 1'b0;
            end
            else if (active && sclk_rise && !overrun)
            begin
                if (clk_cnt == 5'h_10)
                begin
                    overrun               <= 1'b1;
                    ser_fault_set         <= 1'b1;
                    serial_out_pin_oe_out <= 1'b0;
                    serial_out_pin_out    <= 1'b0;
                end
                else
                begin
                    serial_out_pin_out <= shreg[15];
                    shreg   <= {shreg[14:0], 1'b0};
                    clk_cnt <= clk_cnt + 5'h_01;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // error pin
    // ---------------------------------------------------------------
    reg [31:0] hold_cnt;
    reg        err_low;
    wire any_err_ser = |status_word_out[10:5];
    // raw_err[0] is the power-on flag, not an error: bits 5-10 only
    wire any_err_raw = |raw_err[6:1];

    always @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            err_low  <= 1'b0;
            hold_cnt <= 32'h_0000_0000;
        end
        else if (!simple)
        begin
            hold_cnt <= 32'h_0000_0000;
            err_low  <= any_err_ser && stby_n;
        end
        else if (any_err_raw)
        begin
            err_low  <= 1'b1;
            hold_cnt <= ERR_HOLD_CYC;
        end
        else if (hold_cnt != 32'h_0000_0000)
            hold_cnt <= hold_cnt - 32'h_0000_0001;
        else
            err_low <= 1'b0;
    end
    assign error_out_low_out = ~err_low;
endmodule // tssr_status_readout

// ==== test/tssr_monitor.sv ====
// Purpose: port checker for the status readout block
// Assumes: sim counts of 100 cycles for detect, 10 for error hold
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
module tssr_monitor (
    input wire        core_clk_in,            // clock
    input wire        rst_n_in,               // reset, low
    input wire [10:0] flags_in,               // raw flags
    input wire        standby_control_low_in, // standby pin
    input wire        select_line_low_in,     // select pin
    input wire        serial_out_pin_out,     // data level
    input wire        serial_out_pin_oe_out,  // data enable
    input wire        error_out_low_out,      // error pin
    input wire        select_pull_up_out,     // pull-up
    input wire        select_pull_down_out,   // pull-down
    input wire        simple_mode_out,        // simple mode
    input wire [15:0] status_word_out         // status word
);
// ----------------------------------------
// port relations
// ----------------------------------------
default clocking @(posedge core_clk_in); endclocking
default disable iff (!rst_n_in);
a_rsvd_bits:
assert property (status_word_out[14:11] == 4'h_a) else $error("reserved");
a_parity_bit:
assert property (status_word_out[15] == ^status_word_out[14:0])
    else $error("parity");
a_pull_modes:
assert property (select_pull_down_out == simple_mode_out
    && select_pull_up_out == !simple_mode_out) else $error("pulls");
a_uv_blocks:
assert property (flags_in[9] [*3] |=> $stable(simple_mode_out))
    else $error("mode change in undervoltage");
a_idle_tristate:
assert property (select_line_low_in [*6] |-> !serial_out_pin_oe_out)
    else $error("driven while deselected");
a_start_low:
assert property ($fell(select_line_low_in) && !simple_mode_out
    && !flags_in[9] |-> ##[1:8] (serial_out_pin_oe_out
    && !serial_out_pin_out)) else $error("no low at start");
a_err_serial:
assert property ((!simple_mode_out && standby_control_low_in
    && status_word_out[1] && |status_word_out[10:5]) [*6]
    |-> !error_out_low_out) else $error("error pin high");
a_simple_err:
assert property (simple_mode_out && |flags_in[10:5]
    |-> ##[0:4] !error_out_low_out) else $error("simple error late");
a_err_hold:
assert property (simple_mode_out && $fell(error_out_low_out)
    |=> !error_out_low_out [*8]) else $error("error hold short");
endmodule // tssr_monitor
bind tssr_status_readout tssr_monitor u_tssr_monitor (.core_clk_in,
    .rst_n_in, .flags_in, .standby_control_low_in, .select_line_low_in,
    .serial_out_pin_out, .serial_out_pin_oe_out, .error_out_low_out,
    .select_pull_up_out, .select_pull_down_out, .simple_mode_out,
    .status_word_out);

// ==== test/tssr_host_model.sv ====
// Purpose: host that reads the status word serially
// Assumes: link tick of 125 ns, serial clock period 500 ns
// Notes:   tasks are called from the bench
`timescale 1ns/1ns
module tssr_host_model (
    input  wire serial_out_pin_out,    // data level
    input  wire serial_out_pin_oe_out, // data enable
    output reg  select_line_low_in,    // select, low active
    output reg  serial_clk_in          // serial clock
);
reg lclk;
// ----------------------------------------
// link tick and transfers
// ----------------------------------------
initial
begin
    select_line_low_in = 1'b1;
    serial_clk_in = 1'b0;
    lclk = 1'b0;
    forever
    begin
        #63 lclk = 1'b1;
        #62 lclk = 1'b0;
    end
end
task tk(input integer n);
    repeat (n) @(posedge lclk);
endtask
task xfer(input integer n, output [15:0] w, output d0, output dn);
    integer k;
begin
    tk(1);
    select_line_low_in <= 1'b0;
    tk(2);
    d0 = serial_out_pin_oe_out && !serial_out_pin_out;
    w = 16'h_0000;
    dn = 1'b0;
    for (k = 0; k < n; k = k + 1)
    begin
        serial_clk_in <= 1'b1;
        tk(2);
        w = {w[14:0], serial_out_pin_out};
        dn = serial_out_pin_oe_out;
        serial_clk_in <= 1'b0;
        tk(2);
    end
    select_line_low_in <= 1'b1;
    tk(2);
end
endtask
task enter_simple;
begin
    tk(1);
    serial_clk_in <= 1'b1;
    tk(1);
    select_line_low_in <= 1'b0;
    tk(4);
    serial_clk_in <= 1'b0;
end
endtask
task leave_simple;
begin
    tk(1);
    select_line_low_in <= 1'b1;
    tk(2);
end
endtask
endmodule // tssr_host_model

// ==== test/testbench.sv ====
// Purpose: self-checking bench of the status readout block
// Assumes: detect count 100 cycles (above a clock high phase), hold 10
// Notes:   host model does all serial traffic
`timescale 1ns/1ns
module testbench;
reg         core_clk_in;
reg         rst_n_in;
reg         power_off_in;
reg         standby_control_low_in;
reg  [10:0] flags_in;
wire        select_line_low_in, serial_clk_in, serial_out_pin_out;
wire        serial_out_pin_oe_out, error_out_low_out, select_pull_up_out;
wire        select_pull_down_out, simple_mode_out;
wire [15:0] status_word_out;
integer     failures, n_tests, i;
reg  [15:0] w;
reg         d0, dn;
tssr_status_readout #(.DETECT_CYC(100), .ERR_HOLD_CYC(10))
    u_tssr_status_readout (.core_clk_in, .rst_n_in, .power_off_in,
    .flags_in, .standby_control_low_in, .select_line_low_in,
    .serial_clk_in, .serial_out_pin_out, .serial_out_pin_oe_out,
    .error_out_low_out, .select_pull_up_out, .select_pull_down_out,
    .simple_mode_out, .status_word_out);
tssr_host_model u_tssr_host_model (.serial_out_pin_out,
    .serial_out_pin_oe_out, .select_line_low_in, .serial_clk_in);
// ----------------------------------------
// helpers
// ----------------------------------------
initial
begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
end
task cyc(input integer n);
    repeat (n) @(posedge core_clk_in);
endtask
task check(input [79:0] nm, input [15:0] s, input [15:0] e);
begin
    n_tests = n_tests + 1;
    if (s !== e)
    begin
        failures = failures + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
    end
end
endtask
function [15:0] mk(input [6:0] lat);
    mk = {^{4'h_a, lat, 4'h_2}, 4'h_a, lat, 4'h_2};
endfunction
task rd;
    u_tssr_host_model.xfer(16, w, d0, dn);
endtask
task end_sim;
begin
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
initial
begin
    #300000;
    failures = failures + 1;
    end_sim;
end
// ----------------------------------------
// sequence
// ----------------------------------------
initial
begin
    failures = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    power_off_in = 1'b0;
    standby_control_low_in = 1'b1;
    flags_in = 11'h_002;
    cyc(10);
    rst_n_in <= 1'b1;
    cyc(5);
    check("mode", simple_mode_out, 0);
    rd;
    check("first", w, mk(7'h_00));
    check("lowstart", d0, 1);
    $display("idle test done");
    for (i = 4; i < 11; i = i + 1)
    begin
        flags_in[i] <= 1'b1;
        cyc(2);
        flags_in[i] <= 1'b0;
        cyc(12);
        check("latched", status_word_out[i], 1);
        check("errlow", error_out_low_out, i < 5);
        rd;
        check("word", w, mk(7'h_01 << (i - 4)));
        cyc(12);
        check("cleared", status_word_out[10:4], 0);
        check("errhigh", error_out_low_out, 1);
    end
    $display("latch test done");
    flags_in[5] <= 1'b1;
    cyc(2);
    flags_in[5] <= 1'b0;
    standby_control_low_in <= 1'b0;
    cyc(8);
    check("standby", error_out_low_out, 1);
    power_off_in <= 1'b1;
    cyc(3);
    power_off_in <= 1'b0;
    standby_control_low_in <= 1'b1;
    cyc(3);
    check("poweroff", status_word_out[10:4], 0);
    u_tssr_host_model.xfer(17, w, d0, dn);
    cyc(12);
    check("overoe", dn, 0);
    check("overflag", status_word_out[10], 1);
    rd;
    check("faultword", w, mk(7'h_40));
    u_tssr_host_model.xfer(8, w, d0, dn);
    cyc(12);
    check("short", status_word_out[10], 1);
    rd;
    $display("fault test done");
    flags_in[9] <= 1'b1;
    cyc(4);
    rd;
    check("uvrefuse", d0, 0);
    u_tssr_host_model.enter_simple;
    cyc(12);
    check("uvblock", simple_mode_out, 0);
    u_tssr_host_model.leave_simple;
    flags_in[9] <= 1'b0;
    rd;
    rd;
    cyc(12);
    check("uvclear", status_word_out[10:4], 0);
    $display("undervoltage test done");
    u_tssr_host_model.enter_simple;
    cyc(12);
    check("simple", simple_mode_out, 1);
    check("pulldown", select_pull_down_out, 1);
    flags_in[7] <= 1'b1;
    cyc(4);
    check("errfast", error_out_low_out, 0);
    flags_in[7] <= 1'b0;
    cyc(2);
    check("nolatch", status_word_out[7], 0);
    check("hold", error_out_low_out, 0);
    cyc(20);
    check("release", error_out_low_out, 1);
    u_tssr_host_model.leave_simple;
    cyc(12);
    check("back", simple_mode_out, 0);
    $display("simple mode test done");
    end_sim;
end
endmodule // testbench
